// file: hdl/vrc_pkg.sv
// Purpose: shared constants for the reference code generator
// Assumes: 32-bit axi4-lite register bus, one pixel clock domain
// Notes:   register offsets are byte addresses
package vrc_pkg;

  // register map
  localparam logic [3:0] VRC_OFF_CTRL   = 4'h0;
  localparam logic [3:0] VRC_OFF_STATUS = 4'h4;
  localparam logic [3:0] VRC_OFF_REF    = 4'h8;

  // control fields and reset values
  localparam int         VRC_CTRL_HDR_BIT = 0;
  localparam int         VRC_CTRL_VBI_BIT = 1;
  localparam logic [1:0] VRC_CTRL_RST     = 2'h0;

  // status fields
  localparam int VRC_ST_TASK_BIT  = 0;
  localparam int VRC_ST_FIELD_BIT = 1;
  localparam int VRC_ST_VBLK_BIT  = 2;
  localparam int VRC_ST_ARMED_BIT = 3;
  localparam int VRC_ST_FAULT_LSB = 8;

  // number of watched timing strobes
  localparam int VRC_NSTROBE = 5;

  // reference byte layout
  localparam int VRC_T_BIT = 7;
  localparam int VRC_F_BIT = 6;
  localparam int VRC_V_BIT = 5;
  localparam int VRC_H_BIT = 4;

  // code preamble and length
  localparam logic [7:0] VRC_PRE0     = 8'hff;
  localparam logic [7:0] VRC_PRE1     = 8'h00;
  localparam logic [1:0] VRC_LAST_IDX = 2'h3;

  // flag values after reset: active video, even field, blanking
  localparam logic VRC_T_RST = 1'b1;
  localparam logic VRC_F_RST = 1'b1;
  localparam logic VRC_V_RST = 1'b1;
  localparam logic [7:0] VRC_REF_RST = 8'h00;

  // axi responses
  localparam logic [1:0] VRC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VRC_RESP_SLVERR = 2'h2;

endpackage : vrc_pkg

// file: hdl/vrc_gen.sv
// Purpose: insert start/end of active video reference codes into a
//          byte stream and track the task, field and blanking flags
// Assumes: timing strobes and pixel bytes come from logic on aclk
// Notes:   a code overwrites the four stream bytes that follow its edge
module vrc_gen
  import vrc_pkg::*;
#(
  parameter int ADDR_W = 4
)(
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // video timing strobes
  input  wire logic              horizontal_active_window,
  input  wire logic              vertical_active_window,
  input  wire logic              vertical_sync_n,
  input  wire logic              vbi_line_select,
  input  wire logic              last_non_vbi_line,
  input  wire logic              last_non_video_line,
  input  wire logic              last_field_line,
  input  wire logic              last_active_line,
  // pixel stream
  input  wire logic [7:0]        pixel_in,
  output logic [7:0]             video_out_q,
  output logic                   code_out_q
);

  // reference byte with its protection bits
  function automatic logic [7:0] vrc_ref_byte(input logic t, input logic f,
                                              input logic v, input logic h);
    logic [7:0] b;
    b = 8'h00;
    b[VRC_T_BIT] = t;
    b[VRC_F_BIT] = f;
    b[VRC_V_BIT] = v;
    b[VRC_H_BIT] = h;
    b[3] = v ^ h ^ ~t;
    b[2] = f ^ h ^ ~t;
    b[1] = f ^ v ^ ~t;
    b[0] = f ^ v ^ h;
    return b;
  endfunction : vrc_ref_byte

  // state
  logic [1:0]             ctrl_q;
  logic                   t_q;
  logic                   f_q;
  logic                   v_q;
  logic                   armed_q;
  logic [7:0]             last_ref_q;
  logic                   hact_q;
  logic                   vact_q;
  logic                   last_field_line_q;
  logic                   tclr_ev_q;
  logic                   tset_ev_q;
  logic                   tclr_pend_q;
  logic                   tset_pend_q;
  logic                   ftog_pend_q;
  logic                   busy_q;
  logic [1:0]             idx_q;
  logic [7:0]             ref_q;
  logic [VRC_NSTROBE-1:0] fault_q;
  logic                   aw_got_q;
  logic                   w_got_q;
  logic [ADDR_W-1:0]      awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic [1:0]             bresp_q;
  logic                   bvalid_q;
  logic [31:0]            rdata_q;
  logic [1:0]             rresp_q;
  logic                   rvalid_q;

  // combinational terms
  logic                   hdr_en;
  logic                   vbi_en;
  logic                   hrise;
  logic                   hfall;
  logic                   vrise;
  logic                   start_sav;
  logic                   start_eav;
  logic                   tclr_ev;
  logic                   tset_ev;
  logic                   tclr_eff;
  logic                   tset_eff;
  logic                   ftog_eff;
  logic                   t_new;
  logic                   f_new;
  logic                   v_new;
  logic                   wr_fire;
  logic                   aw_hs;
  logic                   w_hs;
  logic [ADDR_W-1:0]      wa;
  logic [31:0]            wd;
  logic [3:0]             ws;
  logic [VRC_NSTROBE-1:0] strobes;
  logic [VRC_NSTROBE-1:0] fault_set;
  logic [31:0]            status_word;

  assign hdr_en = ctrl_q[VRC_CTRL_HDR_BIT];
  assign vbi_en = ctrl_q[VRC_CTRL_VBI_BIT];

  // window edges against last cycle's sample
  assign hrise = horizontal_active_window & ~hact_q;
  assign hfall = ~horizontal_active_window & hact_q;
  assign vrise = vertical_active_window & ~vact_q;

  // codes only once armed; a new edge during a code is dropped
  assign start_sav = hdr_en & armed_q & ~busy_q & hrise;
  assign start_eav = hdr_en & armed_q & ~busy_q & hfall;

  // task events qualified by capture enable and vbi select
  assign tclr_ev = vbi_en & vbi_line_select & last_non_vbi_line;
  assign tset_ev = vbi_en & vbi_line_select & last_non_video_line;

  // an event in the eav cycle itself still counts
  assign tclr_eff = tclr_pend_q | (tclr_ev & ~tclr_ev_q);
  assign tset_eff = tset_pend_q | (tset_ev & ~tset_ev_q);
  assign ftog_eff = ftog_pend_q | (last_field_line & ~last_field_line_q);

  // flag values carried by the coming end code
  assign t_new = tset_eff ? 1'b1 : (tclr_eff ? 1'b0 : t_q);
  assign f_new = f_q ^ ftog_eff;
  // window drops mid strobe, so the line after reads blanking
  assign v_new = ~vertical_active_window;

  // edge samples
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hact_q    <= 1'b0;
      vact_q    <= 1'b0;
      last_field_line_q   <= 1'b0;
      tclr_ev_q <= 1'b0;
      tset_ev_q <= 1'b0;
    end
    else if (ce)
    begin
      hact_q    <= horizontal_active_window;
      vact_q    <= vertical_active_window;
      last_field_line_q   <= last_field_line;
      tclr_ev_q <= tclr_ev;
      tset_ev_q <= tset_ev;
    end
  end

  // pending events wait for the next end code; consume beats set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tclr_pend_q <= 1'b0;
      tset_pend_q <= 1'b0;
      ftog_pend_q <= 1'b0;
    end
    else if (ce)
    begin
      tclr_pend_q <= start_eav ? 1'b0 : tclr_eff;
      tset_pend_q <= start_eav ? 1'b0 : tset_eff;
      ftog_pend_q <= start_eav ? 1'b0 : ftog_eff;
    end
  end

  // flags move only at end codes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      t_q <= VRC_T_RST;
      f_q <= VRC_F_RST;
      v_q <= VRC_V_RST;
    end
    else if (ce && start_eav)
    begin
      t_q <= t_new;
      f_q <= f_new;
      v_q <= v_new;
    end
  end

  // arm on the first rise of the vertical window
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      armed_q <= 1'b0;
    else if (ce)
    begin
      if (!hdr_en)
        armed_q <= 1'b0;
      else if (vrise)
        armed_q <= 1'b1;
    end
  end

  // code sequencer: preamble then reference byte, back to back
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_q     <= 1'b0;
      idx_q      <= 2'h0;
      ref_q      <= VRC_REF_RST;
      last_ref_q <= VRC_REF_RST;
    end
    else if (ce)
    begin
      if (start_eav)
      begin
        busy_q <= 1'b1;
        idx_q  <= 2'h1;
        // h is one in end codes, giving da, f1, b6, 38, 9d
        ref_q  <= vrc_ref_byte(t_new, f_new, v_new, 1'b1);
      end
      else if (start_sav)
      begin
        busy_q <= 1'b1;
        idx_q  <= 2'h1;
        // h is zero in start codes, giving c7, ec, ab, 25, 80
        ref_q  <= vrc_ref_byte(t_q, f_q, v_q, 1'b0);
      end
      else if (busy_q)
      begin
        idx_q <= idx_q + 2'h1;
        if (idx_q == VRC_LAST_IDX)
        begin
          busy_q     <= 1'b0;
          last_ref_q <= ref_q;
        end
      end
    end
  end

  // byte stream: code bytes replace pixels, else pass through
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      video_out_q <= 8'h00;
      code_out_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (start_eav || start_sav)
      begin
        video_out_q <= VRC_PRE0;
        code_out_q  <= 1'b1;
      end
      else if (busy_q)
      begin
        video_out_q <= (idx_q == VRC_LAST_IDX) ? ref_q : VRC_PRE1;
        code_out_q  <= 1'b1;
        // ref_q holds
      end
      else
      begin
        video_out_q <= pixel_in;
        code_out_q  <= 1'b0;
      end
    end
  end

  // each strobe may span exactly one line start; a second is a fault
  assign strobes = {last_active_line, last_field_line, last_non_video_line,
                    last_non_vbi_line, ~vertical_sync_n};
  genvar gi;
  generate
    for (gi = 0; gi < VRC_NSTROBE; gi++)
    begin : g_watch
      logic [1:0] span_q;
      assign fault_set[gi] = strobes[gi] & start_eav & (span_q != 2'h0);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          span_q <= 2'h0;
        else if (ce)
        begin
          if (!strobes[gi])
            span_q <= 2'h0;
          else if (start_eav && span_q != 2'h2)
            span_q <= span_q + 2'h1;
        end
      end
    end
  endgenerate

  // axi write: address and data taken in either order
  assign s_axi_awready = ce & ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ce & ~w_got_q & ~bvalid_q;
  assign aw_hs   = s_axi_awvalid & s_axi_awready;
  assign w_hs    = s_axi_wvalid & s_axi_wready;
  assign wr_fire = (aw_got_q | aw_hs) & (w_got_q | w_hs) & ~bvalid_q;
  assign wa = aw_got_q ? awaddr_q : s_axi_awaddr;
  assign wd = w_got_q ? wdata_q : s_axi_wdata;
  assign ws = w_got_q ? wstrb_q : s_axi_wstrb;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= VRC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (aw_hs)
        awaddr_q <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wa == VRC_OFF_CTRL || wa == VRC_OFF_STATUS) ?
                    VRC_RESP_OKAY : VRC_RESP_SLVERR;
      end
      else
      begin
        if (aw_hs)
          aw_got_q <= 1'b1;
        if (w_hs)
          w_got_q <= 1'b1;
        if (s_axi_bready)
          bvalid_q <= 1'b0;
      end
    end
  end

  // control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= VRC_CTRL_RST;
    else if (ce && wr_fire && wa == VRC_OFF_CTRL && ws[0])
      ctrl_q <= wd[1:0];
  end

  // sticky faults, write one to clear; a new fault wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fault_q <= '0;
    else if (ce)
    begin
      if (wr_fire && wa == VRC_OFF_STATUS && ws[1])
        fault_q <= (fault_q & ~wd[VRC_ST_FAULT_LSB +: VRC_NSTROBE]) | fault_set;
      else
        fault_q <= fault_q | fault_set;
    end
  end

  always_comb
  begin
    status_word = 32'h0;
    status_word[VRC_ST_TASK_BIT]  = t_q;
    status_word[VRC_ST_FIELD_BIT] = f_q;
    status_word[VRC_ST_VBLK_BIT]  = v_q;
    status_word[VRC_ST_ARMED_BIT] = armed_q;
    status_word[VRC_ST_FAULT_LSB +: VRC_NSTROBE] = fault_q;
  end

  // axi read: one cycle to the answer
  assign s_axi_arready = ce & ~rvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= VRC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid_q <= 1'b1;
        rresp_q  <= VRC_RESP_OKAY;
        case (s_axi_araddr)
          VRC_OFF_CTRL:   rdata_q <= {30'h0, ctrl_q};
          VRC_OFF_STATUS: rdata_q <= status_word;
          VRC_OFF_REF:    rdata_q <= {24'h0, last_ref_q};
          default:
          begin
            rdata_q <= 32'h0;
            rresp_q <= VRC_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : vrc_gen

// file: test/vrc_gen_chk.sv
// Purpose: concurrent checks on the code generator's stream outputs
// Assumes: one clock domain, vertical window quiet near line edges
// Notes:   a code is four bytes; the fourth one is the reference byte
module vrc_gen_chk #(
  parameter int ADDR_W = 4
)(
  // clock, reset, enable
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       ce,
  // timing and stream
  input wire logic       horizontal_active_window,
  input wire logic       vertical_active_window,
  input wire logic [7:0] pixel_in,
  input wire logic [7:0] video_out_q,
  input wire logic       code_out_q
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [7:0] b;
  logic [1:0] cnt_q;
  logic [7:0] last_ref_q;
  logic       sav_end;

  // byte position inside a code, wraps so back-to-back codes still count
  always_ff @(posedge aclk)
    if (!aresetn) cnt_q <= 2'h0;
    else if (code_out_q) cnt_q <= cnt_q + 2'h1;
    else cnt_q <= 2'h0;

  // reference byte of the previous code, so a start code can be held to it
  always_ff @(posedge aclk)
    if (!aresetn) last_ref_q <= 8'h00;
    else if (code_out_q && cnt_q == 2'h3) last_ref_q <= video_out_q;

  // last byte of a start code that follows an end code
  assign b = video_out_q;
  assign sav_end = code_out_q && cnt_q == 2'h3 && !b[4] && last_ref_q[4];

  a_code_len : assert property ($rose(code_out_q) |->
    code_out_q [*4] ##1 !code_out_q) else $error("code not four bytes");
  a_code_preamble : assert property ($rose(code_out_q) |->
    b == 8'hff ##1 b == 8'h00 ##1 b == 8'h00) else $error("bad preamble");
  a_hbit_code : assert property ($rose(code_out_q) |->
    ##3 b[4] == !$past(horizontal_active_window, 4))
    else $error("horizontal bit wrong");
  a_parity_bits : assert property ($rose(code_out_q) |->
    ##3 b[3:0] == {b[5] ^ b[4] ^ ~b[7], b[6] ^ b[4] ^ ~b[7],
                   b[6] ^ b[5] ^ ~b[7], b[6] ^ b[5] ^ b[4]})
    else $error("protection bits wrong");
  a_edge_cause : assert property ($rose(code_out_q) |->
    $past(horizontal_active_window) != $past(horizontal_active_window, 2))
    else $error("code without window edge");
  a_vbit_eav : assert property ($rose(code_out_q) &&
    !$past(horizontal_active_window) |->
    ##3 b[5] == !$past(vertical_active_window, 4))
    else $error("blanking bit wrong");
  a_pass_through : assert property (!code_out_q &&
    $past(aresetn) && $past(ce) |-> b == $past(pixel_in))
    else $error("stream byte altered");
  a_sav_task : assert property (sav_end |->
    b[7] == last_ref_q[7]) else $error("task bit moved in start code");
  a_sav_field : assert property (sav_end |->
    b[6] == last_ref_q[6]) else $error("field bit moved in start code");
  a_sav_vblank : assert property (sav_end |->
    b[5] == last_ref_q[5]) else $error("blank bit moved in start code");
  // a start code never comes without an end code ahead of it in the line
  a_eav_first : assert property (code_out_q && cnt_q == 2'h3 &&
    !b[4] |-> last_ref_q[4]) else $error("start code without end code");
endmodule : vrc_gen_chk

bind vrc_gen vrc_gen_chk #(.ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .horizontal_active_window(horizontal_active_window),
  .vertical_active_window(vertical_active_window),
  .pixel_in(pixel_in), .video_out_q(video_out_q), .code_out_q(code_out_q));

// file: test/vrc_gfx_rx.sv
// Purpose: capture side model that spots codes in the byte stream
// Assumes: pixel bytes never take the reserved values 00 and ff
// Notes:   it sees bytes only, no side flag, and never stalls
module vrc_gfx_rx (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // byte stream
  input  wire logic [7:0] byte_in,
  // captured reference byte
  output logic            ref_valid,
  output logic [7:0]      ref_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [23:0] hist_q;

  // last three bytes seen
  always_ff @(posedge aclk)
    if (!aresetn) hist_q <= 24'h000000;
    else hist_q <= {hist_q[15:0], byte_in};

  // a full preamble marks the present byte as the reference byte
  assign ref_valid = (hist_q == 24'hff0000);
  assign ref_byte  = byte_in;
endmodule : vrc_gfx_rx

// file: test/test_vip_reference_code_generator.sv
// Purpose: self-checking bench for the reference code generator
// Assumes: registers over axi4-lite, one 100 MHz clock
// Notes:   strobes change mid-line so each one spans one line, except last_field_line, held over two to raise a fault
module test_vip_reference_code_generator;
  import vrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // bus, stream and bookkeeping
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic        hwin = 1'b1, vwin = 1'b0, vsync_n = 1'b1, sel = 1'b0;
  logic        lnvbi = 1'b0, lnv = 1'b0, lf = 1'b0, la = 1'b0;
  logic [7:0]  pixel_in = 8'h10, video_out_q, rx_byte;
  logic        code_out_q, rx_valid;
  logic [7:0]  exp_q[$];
  int          n_errors = 0, n_compared = 0, cyc = 0;

  vrc_gen #(.ADDR_W(4)) uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .horizontal_active_window(hwin),
    .vertical_active_window(vwin), .vertical_sync_n(vsync_n),
    .vbi_line_select(sel), .last_non_vbi_line(lnvbi),
    .last_non_video_line(lnv), .last_field_line(lf),
    .last_active_line(la), .pixel_in(pixel_in),
    .video_out_q(video_out_q), .code_out_q(code_out_q));
  vrc_gfx_rx rx (.aclk(aclk), .aresetn(aresetn), .byte_in(video_out_q),
    .ref_valid(rx_valid), .ref_byte(rx_byte));

  always #5 aclk = ~aclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  // one line: end code, blanking, start code, strobes set mid-active
  task automatic line(input logic [6:0] v, input logic [15:0] e);
    int g;
    g = 6 + $urandom % 4;
    if (e !== 16'h0)
    begin
      exp_q.push_back(e[15:8]);
      exp_q.push_back(e[7:0]);
    end
    @(posedge aclk) hwin <= 1'b0;
    repeat (g) @(posedge aclk);
    hwin <= 1'b1;
    repeat (g) @(posedge aclk);
    {vwin, vsync_n, sel, lnvbi, lnv, lf, la} <= v;
    repeat (g) @(posedge aclk);
  endtask : line

  // random pixel bytes, never the reserved 00 or ff
  always @(posedge aclk)
    pixel_in <= 8'h01 + 8'($urandom % 254);

  // each captured reference byte is held against the oldest note
  // an unknown flag after reset counts as a code, so it cannot hide
  always @(posedge aclk)
    if (aresetn && rx_valid !== 1'b0)
    begin
      if (exp_q.size() == 0)
      begin
        n_errors++;
        $display("wrong value at %0t: stray code %h", $time, rx_byte);
      end
      else
        chk({24'h0, rx_byte}, {24'h0, exp_q.pop_front()});
    end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      $display("wrong value at %0t: run timed out", $time);
      close_out();
    end
  end

  initial
  begin
    void'($urandom(52516));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(VRC_OFF_CTRL);
    chk(rd, 32'h0);
    rd_reg(VRC_OFF_STATUS);
    chk(rd, 32'h7);
    rd_reg(4'hc);
    chk({30'h0, resp}, {30'h0, VRC_RESP_SLVERR});
    wr(VRC_OFF_REF, 32'h5a);
    chk({30'h0, resp}, {30'h0, VRC_RESP_SLVERR});
    // clock enable low must freeze the stream byte
    ce <= 1'b0;
    repeat (2) @(posedge aclk);
    rd = {24'h0, video_out_q};
    repeat (4) @(posedge aclk);
    chk({24'h0, video_out_q}, rd);
    ce <= 1'b1;
    $display("register checks done");
    line(7'h20, 16'h0);
    line(7'h20, 16'h0);
    wr(VRC_OFF_CTRL, 32'h3);
    chk({30'h0, resp}, {30'h0, VRC_RESP_OKAY});
    line(7'h60, 16'h0);
    line(7'h60, 16'hdac7);
    line(7'h21, 16'hdac7);
    line(7'h22, 16'hf1ec);
    line(7'h18, 16'hb6ab);
    line(7'h74, 16'h3825);
    line(7'h60, 16'h9d80);
    line(7'h62, 16'h9d80);
    line(7'h62, 16'hdac7);
    line(7'h60, 16'hdac7);
    $display("field sequence done");
    rd_reg(VRC_OFF_REF);
    chk(rd, 32'hc7);
    rd_reg(VRC_OFF_STATUS);
    chk(rd, 32'h80b);
    wr(VRC_OFF_STATUS, 32'h800);
    rd_reg(VRC_OFF_STATUS);
    chk(rd, 32'hb);
    wr(VRC_OFF_CTRL, 32'h1);
    line(7'h58, 16'hdac7);
    line(7'h60, 16'hdac7);
    wr(VRC_OFF_CTRL, 32'h0);
    line(7'h60, 16'h0);
    rd_reg(VRC_OFF_STATUS);
    chk({31'h0, rd[3]}, 32'h0);
    // a write without its low byte lane must leave control untouched
    wstrb <= 4'he;
    wr(VRC_OFF_CTRL, 32'h3);
    wstrb <= 4'hf;
    chk({30'h0, resp}, {30'h0, VRC_RESP_OKAY});
    rd_reg(VRC_OFF_CTRL);
    chk(rd, 32'h0);
    chk(exp_q.size(), 32'h0);
    $display("capture and bypass done");
    close_out();
  end
endmodule : test_vip_reference_code_generator
